// ---- dv/spcc_top_props.sv ----
`timescale 1ns/1ps
module spcc_top_props (
   input wire logic clk_i, // bus clock
   input wire logic rst_i, // sync reset
   input wire logic ce_i, // clock enable
   input wire logic wb_cyc_i, // cycle
   input wire logic wb_stb_i, // strobe
   input wire logic wb_we_i, // write
   input wire logic [5:0] wb_adr_i, // address
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // ack
   input wire logic wb_err_o, // error
   input wire logic std_video_model_enable_i, // model enable
   input wire logic socket_idle_i, // idle
   input wire logic host_clk_stopping_i, // host stopping
   input wire logic card_clock_stop_ok_o, // stop allowed
   input wire logic video_path_enable_o, // video on
   input wire logic [2:0] card_supply_o, // card code
   input wire logic [2:0] program_supply_o, // program code
   input wire logic supply_refused_o // refused
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire rd_ctrl;
   assign rd_ctrl = wb_ack_o && !wb_we_i && wb_adr_i == spcc_pkg::SPCC_CTRL_OFFS;
   a_ack_answers: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
      && ce_i |=> wb_ack_o || wb_err_o) else $error("request not answered");
   a_ack_pulse: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
   a_rsvd_zero: assert property (rd_ctrl |-> wb_dat_o[31:12] == '0
      && !wb_dat_o[8] && !wb_dat_o[3]) else $error("reserved bit set");
   a_model_bit: assert property (rd_ctrl |-> wb_dat_o[10] ==
      !$past(std_video_model_enable_i)) else $error("model bit wrong");
   a_video_bit: assert property (rd_ctrl |-> wb_dat_o[9] == video_path_enable_o)
      else $error("video bit mismatch");
   a_activity_bit: assert property (rd_ctrl && wb_dat_o[9] |-> wb_dat_o[11])
      else $error("activity bit clear");
   a_stop_busy: assert property ($past(ce_i && !rst_i && !socket_idle_i)
      |-> !card_clock_stop_ok_o) else $error("stop while busy");
   a_stop_host: assert property ($past(ce_i && !rst_i && socket_idle_i)
      && $past(host_clk_stopping_i) |-> card_clock_stop_ok_o) else $error("stop withheld");
   a_supply_codes: assert property (card_supply_o != 3'h1 && card_supply_o < 3'h6
      && program_supply_o < 3'h6) else $error("reserved code applied");
   a_refused_hold: assert property (supply_refused_o && $past(supply_refused_o)
      |-> $stable(card_supply_o) && $stable(program_supply_o)) else $error("refused applied");
endmodule : spcc_top_props
bind spcc_top spcc_top_props spcc_top_props_i (.clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .std_video_model_enable_i,
   .socket_idle_i, .host_clk_stopping_i, .card_clock_stop_ok_o, .video_path_enable_o,
   .card_supply_o, .program_supply_o, .supply_refused_o);

// ---- dv/testbench.sv ----
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module testbench;
   logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, std_en = 0, idle = 0, host = 0, ce = 1;
   logic [5:0] adr = '0;
   logic [3:0] sel = '0, cap = 4'hf;
   logic [31:0] wdat = '0, rdat, q;
   logic ack, err, e, stop_ok, ven, refused, locked;
   logic [2:0] sup, prg;
   int mismatches = 0, samples_checked = 0, cycles = 0;
   typedef struct packed {logic [31:0] wr; logic [31:0] rd; logic [2:0] s; logic [2:0] p;} spcc_row_s;
   spcc_row_s rows [6] = '{'{32'hffff_ffab, 32'h0000_0ea3, 3'h2, 3'h3},
      '{32'h44, 32'h444, 3'h4, 3'h4}, '{32'h55, 32'h455, 3'h5, 3'h5},
      '{32'h32, 32'h432, 3'h3, 3'h2}, '{32'h01, 32'h401, 3'h0, 3'h1}, '{32'h0, 32'h400, 3'h0, 3'h0}};
   spcc_top spcc_top_i (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .wb_err_o(err), .std_video_model_enable_i(std_en), .card_cap_i(cap), .socket_idle_i(idle),
      .host_clk_stopping_i(host), .card_clock_stop_ok_o(stop_ok), .video_path_enable_o(ven),
      .card_supply_o(sup), .program_supply_o(prg), .supply_refused_o(refused),
      .ctrl_disabled_o(locked));
   initial forever #50 clk_i = ~clk_i;
   task automatic final_report;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   // waits for ack or err, then leaves time for the applied supply codes to follow
   task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
      cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d; sel <= 4'hf;
      do @(posedge clk_i); while (!(ack || err));
      q = rdat; e = err;
      cyc <= 0; stb <= 0;
      repeat (3) @(posedge clk_i);
   endtask : bus
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 4000) begin mismatches++; final_report(); end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      @(posedge clk_i);
      bus(0, 6'h10, 0); `CHK("ctrl reset", 32'h0000_0400, q)
      bus(1, 6'h0c, 32'h4000);
      foreach (rows[i]) begin
         bus(1, 6'h10, rows[i].wr); bus(0, 6'h10, 0);
         `CHK("ctrl read", rows[i].rd, q)
         `CHK("video path", rows[i].rd[9], ven)
         `CHK("card supply", rows[i].s, sup)
         `CHK("program supply", rows[i].p, prg)
      end
      // a nonzero accepted pair first, so that holding is visible
      bus(1, 6'h10, 32'h33);
      bus(1, 6'h10, 32'h17); `CHK("refused", 1'b1, refused)
      `CHK("held supply", 3'h3, sup)
      bus(1, 6'h10, 32'h76); `CHK("refused", 1'b1, refused)
      `CHK("held program", 3'h3, prg)
      $display("done: table and reserved codes");
      cap <= 4'h1;
      repeat (3) @(posedge clk_i);
      bus(1, 6'h0c, 32'h4000); bus(1, 6'h10, 32'h30);
      `CHK("3v3 refused", 1'b1, refused)
      `CHK("3v3 held", 3'h3, sup)
      bus(1, 6'h10, 32'h20); `CHK("5v applied", 3'h2, sup)
      bus(1, 6'h0c, 32'h0800); `CHK("locked", 1'b1, locked)
      bus(1, 6'h10, 32'h0); bus(0, 6'h10, 0); `CHK("locked read", 32'h420, q)
      `CHK("locked supply", 3'h2, sup)
      bus(1, 6'h0c, 32'h4000); `CHK("unlocked", 1'b0, locked)
      bus(1, 6'h10, 32'h0); `CHK("supply off", 3'h0, sup)
      $display("done: capability and lock");
      bus(1, 6'h14, 32'h1); std_en <= 1;
      bus(0, 6'h10, 0); `CHK("peer video", 32'h0000_0800, q)
      bus(1, 6'h14, 32'h0); std_en <= 0;
      bus(0, 6'h20, 0); `CHK("unmapped", 1'b1, e)
      bus(0, 6'h0c, 0); `CHK("force read", 32'h0, q)
      for (int i = 0; i < 8; i++) begin
         idle <= i[1]; host <= i[0]; bus(1, 6'h10, {24'h0, i[2], 7'h0});
         `CHK("clock stop", i[1] & (i[2] | i[0]), stop_ok)
      end
      $display("done: status bits and clock policy");
      // request held while the enable is low must wait, then land
      ce <= 0;
      fork
         bus(1, 6'h10, 32'h20);
         begin
            repeat (4) @(posedge clk_i);
            `CHK("frozen ack", 1'b0, ack)
            ce <= 1;
         end
      join
      bus(0, 6'h10, 0); `CHK("frozen write", 32'h0000_0420, q)
      $display("done: clock enable");
      bus(1, 6'h10, 32'h222);
      rst_i <= 1;
      repeat (2) @(posedge clk_i);
      `CHK("supply in reset", 3'h0, sup)
      `CHK("video in reset", 1'b0, ven)
      rst_i <= 0;
      @(posedge clk_i);
      bus(0, 6'h10, 0); `CHK("ctrl rereset", 32'h0000_0400, q)
      $display("done: second reset");
      final_report();
   end
endmodule : testbench

// ---- hdl/spcc_pkg.sv ----
package spcc_pkg;
   localparam int unsigned SPCC_ADDR_W = 6;
   // register byte offsets within the socket space
   localparam logic [5:0] SPCC_FORCE_OFFS = 6'h0c;
   localparam logic [5:0] SPCC_CTRL_OFFS = 6'h10;
   localparam logic [5:0] SPCC_PEER_OFFS = 6'h14;
   localparam logic [31:0] SPCC_CTRL_RESET = 32'h0000_0400;
   // control field positions
   localparam int unsigned SPCC_PRG_LSB = 0;
   localparam int unsigned SPCC_SUP_LSB = 4;
   localparam int unsigned SPCC_STOP_BIT = 7;
   localparam int unsigned SPCC_VEN_BIT = 9;
   localparam int unsigned SPCC_STDM_BIT = 10;
   localparam int unsigned SPCC_ACT_BIT = 11;
   // force-event bits that touch this register
   localparam int unsigned SPCC_FRC_YV_BIT = 13;
   localparam int unsigned SPCC_FRC_XV_BIT = 12;
   localparam int unsigned SPCC_FRC_3V_BIT = 11;
   localparam int unsigned SPCC_FRC_5V_BIT = 10;
   localparam int unsigned SPCC_REINT_BIT = 14;
   // supply codes
   localparam logic [2:0] SPCC_V_OFF = 3'h0;
   localparam logic [2:0] SPCC_V_12 = 3'h1;
   localparam logic [2:0] SPCC_V_5 = 3'h2;
   localparam logic [2:0] SPCC_V_33 = 3'h3;
   localparam logic [2:0] SPCC_V_XX = 3'h4;
   localparam logic [2:0] SPCC_V_YY = 3'h5;
   // card capability vector: {yy, xx, 3v3, 5v}
   localparam logic [3:0] SPCC_CAP_NONE = 4'h0;
endpackage : spcc_pkg

// ---- hdl/spcc_top.sv ----
`timescale 1ns/1ps
// Contract
// - bits 31..12 all read zero, writes ignored
// - bit 8 reads zero, writes to it change nothing
// - bit 3 reads zero
// - bit 11 is one when either socket has video enabled
// - bit 10 is one while the standard video model enable is clear
// - bit 9 enables the video path for this socket
// - stop policy 0: stop clock only if idle and host clock stopping
// - stop policy 1: stop clock whenever socket idle
// - card supply codes 000 off,010 5V,011 3.3V,100 X.X,101 Y.Y; others reserved
// - program supply codes 000 off,001 12V,010,011,100,101; 110,111 reserved
// - apply voltages the inserted card accepts, refuse others; a refusal of either code holds both last applied codes, even for the accepted field
// - register at offset 10h, 32 bits, reset 0000_0400h
// - forced voltage capability write disables this register until reinterrogation
// - reinterrogate bit re-probes card and re-enables this register
module spcc_top (
   input wire logic clk_i,                 // bus clock, 10 MHz
   input wire logic rst_i,                 // synchronous reset, active high
   input wire logic ce_i,                  // clock enable, freezes state when low
   input wire logic wb_cyc_i,              // wishbone cycle
   input wire logic wb_stb_i,              // wishbone strobe
   input wire logic wb_we_i,               // wishbone write
   input wire logic [5:0] wb_adr_i,        // byte address
   input wire logic [3:0] wb_sel_i,        // byte lanes
   input wire logic [31:0] wb_dat_i,       // write data
   output logic [31:0] wb_dat_o,           // read data
   output logic wb_ack_o,                  // acknowledge
   output logic wb_err_o,                  // unmapped address answer
   input wire logic std_video_model_enable_i, // diagnostic model enable bit
   input wire logic [3:0] card_cap_i,      // pin: probed {yy, xx, 3v3, 5v}
   input wire logic socket_idle_i,         // card side idle
   input wire logic host_clk_stopping_i,   // host clock-run preparing to stop
   output logic card_clock_stop_ok_o,      // card clock may be stopped/slowed
   output logic video_path_enable_o,       // this socket's video path on
   output logic [2:0] card_supply_o,       // applied card supply code
   output logic [2:0] program_supply_o,    // applied program supply code
   output logic supply_refused_o,          // last request was refused
   output logic ctrl_disabled_o            // register locked by forced capability
);
   logic [3:0] cap_meta_reg;
   logic [3:0] cap_sync_reg;
   logic [2:0] card_supply_request_reg;
   logic [2:0] program_supply_request_reg;
   logic card_clock_stop_policy_reg;
   logic socket_video_enable_reg;
   logic peer_video_enable_reg;
   logic ctrl_disabled_reg;
   logic [3:0] card_cap_reg;
   logic [2:0] card_supply_reg;
   logic [2:0] program_supply_reg;
   logic refused_reg;
   logic stop_ok_reg;
   logic ack_reg;
   logic err_reg;
   logic [31:0] rdata_reg;

   wire req = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   wire hit_ctrl = wb_adr_i == spcc_pkg::SPCC_CTRL_OFFS;
   wire hit_force = wb_adr_i == spcc_pkg::SPCC_FORCE_OFFS;
   wire hit_peer = wb_adr_i == spcc_pkg::SPCC_PEER_OFFS;
   wire mapped = hit_ctrl | hit_force | hit_peer;
   wire wr_ctrl = req & wb_we_i & hit_ctrl & ~ctrl_disabled_reg;
   wire wr_force = req & wb_we_i & hit_force;
   wire wr_peer = req & wb_we_i & hit_peer & wb_sel_i[0];
   wire wr_ctrl_lo = wr_ctrl & wb_sel_i[0];
   wire wr_ctrl_hi = wr_ctrl & wb_sel_i[1];
   wire [2:0] new_card = wb_dat_i[spcc_pkg::SPCC_SUP_LSB +: 3];
   wire [2:0] new_prog = wb_dat_i[spcc_pkg::SPCC_PRG_LSB +: 3];
   wire reint = wr_force & wb_sel_i[1] & wb_dat_i[spcc_pkg::SPCC_REINT_BIT];
   // forced capabilities live in bits 13..10 of force event
   wire [3:0] forced_cap = {wb_dat_i[spcc_pkg::SPCC_FRC_YV_BIT],
      wb_dat_i[spcc_pkg::SPCC_FRC_XV_BIT], wb_dat_i[spcc_pkg::SPCC_FRC_3V_BIT],
      wb_dat_i[spcc_pkg::SPCC_FRC_5V_BIT]};
   wire force_cap = wr_force & wb_sel_i[1] & (|forced_cap);
   wire card_ok;
   wire prog_ok;
   wire [3:0] cap_next = reint ? cap_sync_reg :
      (force_cap ? (card_cap_reg | forced_cap) : card_cap_reg);

   spcc_volt_check u_card_chk (
      .code_i(card_supply_request_reg),
      .allow_12_i(1'b0),
      .cap_i(card_cap_reg),
      .ok_o(card_ok)
   );
   spcc_volt_check u_prog_chk (
      .code_i(program_supply_request_reg),
      .allow_12_i(1'b1),
      .cap_i(card_cap_reg),
      .ok_o(prog_ok)
   );

   wire both_ok = card_ok & prog_ok;
   wire stop_ok_next = socket_idle_i &
      (card_clock_stop_policy_reg | host_clk_stopping_i);

   // read value: reserved bits stay zero
   logic [31:0] ctrl_view;
   always_comb begin
      ctrl_view = 32'h0000_0000;
      ctrl_view[spcc_pkg::SPCC_ACT_BIT] = socket_video_enable_reg | peer_video_enable_reg;
      ctrl_view[spcc_pkg::SPCC_STDM_BIT] = ~std_video_model_enable_i;
      ctrl_view[spcc_pkg::SPCC_VEN_BIT] = socket_video_enable_reg;
      ctrl_view[spcc_pkg::SPCC_STOP_BIT] = card_clock_stop_policy_reg;
      ctrl_view[spcc_pkg::SPCC_SUP_LSB +: 3] = card_supply_request_reg;
      ctrl_view[spcc_pkg::SPCC_PRG_LSB +: 3] = program_supply_request_reg;
   end
   wire [31:0] peer_view = {31'h0000_0000, peer_video_enable_reg};
   // force event is write-only, so it reads zero
   wire [31:0] rdata_next = hit_ctrl ? ctrl_view : (hit_peer ? peer_view : 32'h0000_0000);

   // capability pins come from the card side, so synchronise first
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cap_meta_reg <= spcc_pkg::SPCC_CAP_NONE;
         cap_sync_reg <= spcc_pkg::SPCC_CAP_NONE;
      end else if (ce_i) begin
         cap_meta_reg <= card_cap_i;
         cap_sync_reg <= cap_meta_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg <= 1'b0;
         err_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
      end else if (ce_i) begin
         ack_reg <= req & mapped;
         err_reg <= req & ~mapped;
         if (req) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   // control fields, reset to off per the default word
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         card_supply_request_reg <= spcc_pkg::SPCC_CTRL_RESET[spcc_pkg::SPCC_SUP_LSB +: 3];
         program_supply_request_reg <= spcc_pkg::SPCC_CTRL_RESET[spcc_pkg::SPCC_PRG_LSB +: 3];
         card_clock_stop_policy_reg <= spcc_pkg::SPCC_CTRL_RESET[spcc_pkg::SPCC_STOP_BIT];
         socket_video_enable_reg <= spcc_pkg::SPCC_CTRL_RESET[spcc_pkg::SPCC_VEN_BIT];
         peer_video_enable_reg <= 1'b0;
      end else if (ce_i) begin
         if (wr_ctrl_lo) begin
            card_supply_request_reg <= new_card;
            program_supply_request_reg <= new_prog;
            card_clock_stop_policy_reg <= wb_dat_i[spcc_pkg::SPCC_STOP_BIT];
         end
         if (wr_ctrl_hi) begin
            socket_video_enable_reg <= wb_dat_i[spcc_pkg::SPCC_VEN_BIT];
         end
         if (wr_peer) begin
            peer_video_enable_reg <= wb_dat_i[0];
         end
      end
   end

   // lock and capability: reinterrogation wins over a forced bit in the same write
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_disabled_reg <= 1'b0;
         card_cap_reg <= spcc_pkg::SPCC_CAP_NONE;
      end else if (ce_i) begin
         card_cap_reg <= cap_next;
         if (reint) begin
            ctrl_disabled_reg <= 1'b0;
         end else if (force_cap) begin
            ctrl_disabled_reg <= 1'b1;
         end
      end
   end

   // supply outputs follow the requests only when the card accepts them
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         card_supply_reg <= spcc_pkg::SPCC_V_OFF;
         program_supply_reg <= spcc_pkg::SPCC_V_OFF;
         refused_reg <= 1'b0;
         stop_ok_reg <= 1'b0;
      end else if (ce_i) begin
         stop_ok_reg <= stop_ok_next;
         refused_reg <= ~both_ok;
         if (both_ok) begin
            card_supply_reg <= card_supply_request_reg;
            program_supply_reg <= program_supply_request_reg;
         end
      end
   end

   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign card_clock_stop_ok_o = stop_ok_reg;
   assign video_path_enable_o = socket_video_enable_reg;
   assign card_supply_o = card_supply_reg;
   assign program_supply_o = program_supply_reg;
   assign supply_refused_o = refused_reg;
   assign ctrl_disabled_o = ctrl_disabled_reg;
endmodule : spcc_top

// ---- hdl/spcc_volt_check.sv ----
`timescale 1ns/1ps
// combinational decode of one supply request against card capability
module spcc_volt_check (
   input wire logic [2:0] code_i,     // requested code
   input wire logic allow_12_i,       // 12 V code legal in this field
   input wire logic [3:0] cap_i,      // {yy, xx, 3v3, 5v} card can take
   output logic ok_o                  // request may be applied
);
   always_comb begin
      case (code_i)
         spcc_pkg::SPCC_V_OFF: ok_o = 1'b1;
         spcc_pkg::SPCC_V_12: ok_o = allow_12_i;
         spcc_pkg::SPCC_V_5: ok_o = cap_i[0];
         spcc_pkg::SPCC_V_33: ok_o = cap_i[1];
         spcc_pkg::SPCC_V_XX: ok_o = cap_i[2];
         spcc_pkg::SPCC_V_YY: ok_o = cap_i[3];
         default: ok_o = 1'b0;
      endcase
   end
endmodule : spcc_volt_check
